/* File: verilog/sbl_loader.sv */
// secure boot image loader: security word fetch, image load, crc check, start
`timescale 1ns/1ps
module sbl_loader #(
  parameter int GPIO_W   = 16,
  parameter int RST_CYC  = sbl_pkg::RST_PROC_CYC
) (
  input  wire logic                    clk,
  input  wire logic                    rst_b,
  // otp read port, data one cycle after request
  output logic                         otp_rd_reg,
  output logic [sbl_pkg::OTP_ADDR_W-1:0] otp_addr_reg,
  input  wire logic [31:0]             otp_rdata,
  // flash byte stream
  output logic                         flash_req_reg,
  input  wire sbl_pkg::sbl_byte_t      flash_byte,
  // ram write port and processor start
  output sbl_pkg::sbl_ram_wr_t         ram_wr_reg,
  output logic                         cpu_start_reg,
  output logic [15:0]                  cpu_pc_reg,
  output logic                         boot_err_reg,
  // gpio pull-down enables
  output logic [GPIO_W-1:0]            gpio_pd_reg,
  // security controls
  output sbl_pkg::sbl_sec_ctl_t        sec_ctl_reg,
  output logic [31:0]                  usercode_reg,
  // otp programming request from resource ports
  input  wire logic [23:0]             prog_res_id,
  input  wire logic [15:0]             prog_addr,
  input  wire logic                    prog_req,
  output logic                         prog_grant_reg,
  // register port
  input  wire logic [3:0]              reg_addr,
  input  wire logic [31:0]             reg_wdata,
  input  wire logic                    reg_wr,
  input  wire logic                    reg_rd,
  output logic [31:0]                  reg_rdata_reg
);
  //////////////////////////////////////////////////////////////////////
  // state machine
  typedef enum logic [2:0] {
    S_RESET = 3'b000,  // internal reset process
    S_SEC   = 3'b001,  // read security word
    S_SECW  = 3'b010,  // wait for otp data
    S_LOAD  = 3'b011,  // stream image bytes
    S_DONE  = 3'b100,  // program started
    S_ERR   = 3'b101   // check failed
  } sbl_state_t;

  sbl_state_t  state_reg;            // current state
  logic [31:0] rst_cnt_reg;          // reset process counter
  logic [31:0] sec_reg;              // security word
  logic [1:0]  bidx_reg;             // byte within word
  logic [31:0] word_reg;             // assembling word
  logic [31:0] len_reg;              // program length in words
  logic [31:0] wcnt_reg;             // words received
  logic [1:0]  phase_reg;            // 0 len, 1 prog, 2 check
  logic [31:0] crc_reg;              // running crc
  logic        src_otp_reg;          // boot source otp
  logic        otp_pend_reg;         // otp data due this cycle
  logic        otp_new_reg;          // otp data stands this cycle only
  logic [31:0] otp_word_reg;         // held otp word for later bytes
  logic [7:0]  in_byte;              // current byte
  logic        in_valid;             // byte present
  logic [31:0] word_next;            // word with new byte
  logic [31:0] crc_next;             // crc after new byte

  //////////////////////////////////////////////////////////////////////
  // byte source select: otp words split lsb first, or flash bytes
  always_comb
  begin
    if (src_otp_reg)
    begin
      in_valid = otp_pend_reg;
      // fresh word straight from the array, later bytes from the held copy
      in_byte  = otp_new_reg ? otp_rdata[8*bidx_reg +: 8]
                             : otp_word_reg[8*bidx_reg +: 8];
    end
    else
    begin
      in_valid = flash_byte.valid;
      in_byte  = flash_byte.data;
    end
    word_next = {in_byte, word_reg[31:8]};
  end

  // bitwise reflected crc step
  always_comb
  begin
    crc_next = crc_reg ^ {24'h000000, in_byte};
    for (int i = 0; i < 8; i++)
      crc_next = crc_next[0] ? ((crc_next >> 1) ^ sbl_pkg::CRC_POLY)
                             : (crc_next >> 1);
  end

  //////////////////////////////////////////////////////////////////////
  // main sequencer
  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      state_reg     <= S_RESET;
      rst_cnt_reg   <= 32'h00000000;
      sec_reg       <= 32'h00000000;
      bidx_reg      <= 2'h0;
      word_reg      <= 32'h00000000;
      len_reg       <= 32'h00000000;
      wcnt_reg      <= 32'h00000000;
      phase_reg     <= 2'h0;
      crc_reg       <= sbl_pkg::CRC_INIT;
      src_otp_reg   <= 1'b0;
      otp_pend_reg  <= 1'b0;
      otp_new_reg   <= 1'b0;
      otp_word_reg  <= 32'h00000000;
      otp_rd_reg    <= 1'b0;
      otp_addr_reg  <= '0;
      flash_req_reg <= 1'b0;
      ram_wr_reg    <= '0;
      cpu_start_reg <= 1'b0;
      cpu_pc_reg    <= 16'h0000;
      boot_err_reg  <= 1'b0;
    end
    else
    begin
      otp_rd_reg    <= 1'b0;
      ram_wr_reg.we <= 1'b0;
      otp_pend_reg  <= otp_rd_reg;
      otp_new_reg   <= otp_rd_reg;
      // array data only stands one cycle: keep it for bytes 1 to 3
      if (otp_new_reg)
        otp_word_reg <= otp_rdata;
      unique case (state_reg)
        S_RESET:
        begin
          if (rst_cnt_reg == 32'(RST_CYC - 1))
            state_reg <= S_SEC;
          else
            rst_cnt_reg <= rst_cnt_reg + 32'h00000001;
        end
        S_SEC:
        begin
          otp_rd_reg   <= 1'b1;
          otp_addr_reg <= sbl_pkg::OTP_SEC_ROW;
          state_reg    <= S_SECW;
        end
        S_SECW:
        begin
          if (otp_pend_reg)
          begin
            sec_reg      <= otp_rdata;
            src_otp_reg  <= otp_rdata[sbl_pkg::SEC_OTP_BOOT];
            otp_addr_reg <= sbl_pkg::OTP_BOOT_ROW;
            otp_rd_reg   <= otp_rdata[sbl_pkg::SEC_OTP_BOOT];
            flash_req_reg <= !otp_rdata[sbl_pkg::SEC_OTP_BOOT];
            state_reg    <= S_LOAD;
          end
        end
        S_LOAD:
        begin
          // otp: keep a word in flight while its bytes are consumed
          if (src_otp_reg && otp_pend_reg && bidx_reg != 2'h3)
            otp_pend_reg <= 1'b1;
          if (in_valid)
          begin
            word_reg <= word_next;
            bidx_reg <= bidx_reg + 2'h1;
            if (phase_reg != 2'h2)
              crc_reg <= crc_next;
            if (bidx_reg == 2'h3)
            begin
              if (src_otp_reg)
              begin
                otp_rd_reg   <= 1'b1;
                otp_addr_reg <= otp_addr_reg + 1'b1;
              end
              unique case (phase_reg)
                2'h0:
                begin
                  len_reg   <= word_next;
                  phase_reg <= (word_next == 32'h00000000) ? 2'h2 : 2'h1;
                end
                2'h1:
                begin
                  ram_wr_reg.we   <= 1'b1;
                  ram_wr_reg.addr <= 16'(wcnt_reg << 2);
                  ram_wr_reg.data <= word_next;
                  wcnt_reg        <= wcnt_reg + 32'h00000001;
                  if (wcnt_reg + 32'h00000001 == len_reg)
                    phase_reg <= 2'h2;
                end
                default:
                begin
                  flash_req_reg <= 1'b0;
                  otp_rd_reg    <= 1'b0;
                  if (word_next == sbl_pkg::NO_CRC_MAGIC ||
                      word_next == ~crc_reg)
                  begin
                    cpu_start_reg <= 1'b1;
                    cpu_pc_reg    <= 16'h0000;
                    state_reg     <= S_DONE;
                  end
                  else
                  begin
                    boot_err_reg <= 1'b1;
                    state_reg    <= S_ERR;
                  end
                end
              endcase
            end
          end
        end
        S_DONE: ;
        S_ERR: ;
        default: state_reg <= S_ERR;
      endcase
    end
  end

  //////////////////////////////////////////////////////////////////////
  // gpio pull-downs: on in reset, released when boot starts
  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
      gpio_pd_reg <= '1;
    else if (state_reg != S_RESET)
      gpio_pd_reg <= '0;
  end

  //////////////////////////////////////////////////////////////////////
  // security controls and usercode
  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      sec_ctl_reg  <= '0;
      usercode_reg <= 32'h00000000;
    end
    else
    begin
      sec_ctl_reg.tap_off      <= sec_reg[sbl_pkg::SEC_NO_TAP];
      sec_ctl_reg.link_off     <= sec_reg[sbl_pkg::SEC_NO_LINK];
      sec_ctl_reg.redundant_on <= sec_reg[sbl_pkg::SEC_REDUNDANT];
      sec_ctl_reg.sector_lock  <= sec_reg[sbl_pkg::SEC_LOCK_HI:sbl_pkg::SEC_LOCK_LO];
      sec_ctl_reg.tap_otp_off  <= sec_reg[sbl_pkg::SEC_NO_TAP_OTP];
      usercode_reg <= {sec_reg[sbl_pkg::SEC_UID_HI:sbl_pkg::SEC_UID_LO], 22'h000000};
    end
  end

  //////////////////////////////////////////////////////////////////////
  // otp programming gate: sector from row address, three resource ports
  logic [1:0] prog_sector;            // addressed sector
  logic       prog_res_ok;            // known resource
  assign prog_sector = prog_addr[10:9];
  assign prog_res_ok = (prog_res_id == sbl_pkg::RES_OTP_ADDR) ||
                       (prog_res_id == sbl_pkg::RES_OTP_DATA) ||
                       (prog_res_id == sbl_pkg::RES_OTP_CTRL);

  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
      prog_grant_reg <= 1'b0;
    else
      prog_grant_reg <= prog_req && prog_res_ok &&
                        (state_reg == S_DONE || state_reg == S_ERR) &&
                        !sec_reg[sbl_pkg::SEC_MASTER_LOCK] &&
                        !sec_reg[sbl_pkg::SEC_LOCK_LO + 32'(prog_sector)];
  end

  //////////////////////////////////////////////////////////////////////
  // register port: read data one cycle after strobe
  logic [31:0] gp_reg;                // software general purpose copy
  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      gp_reg        <= 32'h00000000;
      reg_rdata_reg <= 32'h00000000;
    end
    else
    begin
      if (state_reg == S_SECW && otp_pend_reg)
        gp_reg <= {25'h0000000, otp_rdata[sbl_pkg::SEC_GP_HI:sbl_pkg::SEC_GP_LO]};
      else if (reg_wr && reg_addr == sbl_pkg::REG_GP)
        gp_reg <= {25'h0000000, reg_wdata[6:0]};
      reg_rdata_reg <= 32'h00000000;
      if (reg_rd)
        unique case (reg_addr)
          sbl_pkg::REG_SEC:     reg_rdata_reg <= sec_reg;
          sbl_pkg::REG_STATUS:  reg_rdata_reg <= {28'h0000000, src_otp_reg,
                                  boot_err_reg, cpu_start_reg,
                                  state_reg != S_DONE && state_reg != S_ERR};
          sbl_pkg::REG_GP:      reg_rdata_reg <= gp_reg;
          sbl_pkg::REG_USERC:   reg_rdata_reg <= usercode_reg;
          sbl_pkg::REG_PROGLEN: reg_rdata_reg <= len_reg;
          sbl_pkg::REG_CRC:     reg_rdata_reg <= ~crc_reg;
          default:              reg_rdata_reg <= 32'h00000000;
        endcase
    end
  end

  //////////////////////////////////////////////////////////////////////
  // assertions
  a_pd_release: assert property (@(posedge clk) disable iff (!rst_b)
    (state_reg == S_RESET) |=> gpio_pd_reg == '1)
    else $error("pull-downs dropped during reset process");
  a_no_early_boot: assert property (@(posedge clk) disable iff (!rst_b)
    (state_reg != S_RESET) |-> rst_cnt_reg == 32'(RST_CYC - 1))
    else $error("boot began before reset wait");
  a_start_pc_zero: assert property (@(posedge clk) disable iff (!rst_b)
    $rose(cpu_start_reg) |-> cpu_pc_reg == 16'h0000)
    else $error("start address not zero");
  a_err_no_start: assert property (@(posedge clk) disable iff (!rst_b)
    boot_err_reg |-> !cpu_start_reg)
    else $error("error and start together");
  a_master_lock: assert property (@(posedge clk) disable iff (!rst_b)
    sec_reg[sbl_pkg::SEC_MASTER_LOCK] |=> !prog_grant_reg)
    else $error("programming granted under master lock");
  a_tap_off: assert property (@(posedge clk) disable iff (!rst_b)
    sec_reg[sbl_pkg::SEC_NO_TAP] |=> sec_ctl_reg.tap_off)
    else $error("test port not disabled");
  // a fresh otp word must always be split from its lowest byte
  a_otp_fresh_lsb: assert property (@(posedge clk) disable iff (!rst_b)
    otp_new_reg |-> bidx_reg == 2'h0)
    else $error("otp word arrived mid word");
endmodule

/* File: verilog/sbl_pkg.sv */
// package: constants, types and layouts for the secure boot image loader
package sbl_pkg;
  // security word bit positions
  localparam int SEC_NO_TAP      = 0;
  localparam int SEC_NO_LINK     = 1;
  localparam int SEC_OTP_BOOT    = 5;
  localparam int SEC_REDUNDANT   = 7;
  localparam int SEC_LOCK_LO     = 8;
  localparam int SEC_LOCK_HI     = 11;
  localparam int SEC_MASTER_LOCK = 12;
  localparam int SEC_NO_TAP_OTP  = 13;
  localparam int SEC_GP_LO       = 15;
  localparam int SEC_GP_HI       = 21;
  localparam int SEC_UID_LO      = 22;
  localparam int SEC_UID_HI      = 31;
  localparam int NUM_SECTORS     = 4;
  localparam int SECTOR_ROWS     = 512;
  localparam int OTP_ADDR_W      = 11;
  localparam logic [OTP_ADDR_W-1:0] OTP_SEC_ROW  = 11'h7FF; // security word row
  localparam logic [OTP_ADDR_W-1:0] OTP_BOOT_ROW = 11'h000; // image start row
  // otp programming port resource identifiers
  localparam logic [23:0] RES_OTP_ADDR = 24'h100200;
  localparam logic [23:0] RES_OTP_DATA = 24'h200100;
  localparam logic [23:0] RES_OTP_CTRL = 24'h100300;
  // crc
  localparam logic [31:0] CRC_POLY     = 32'hEDB88320;
  localparam logic [31:0] CRC_INIT     = 32'hFFFFFFFF;
  localparam logic [31:0] NO_CRC_MAGIC = 32'h0D15AB1E;
  // timing: internal reset process before boot
  localparam int CLK_MHZ       = 40;
  localparam int RST_PROC_US   = 15;
  localparam int RST_PROC_CYC  = RST_PROC_US * CLK_MHZ;
  // register map over the plain port
  localparam logic [3:0] REG_SEC     = 4'h0;
  localparam logic [3:0] REG_STATUS  = 4'h1;
  localparam logic [3:0] REG_GP      = 4'h2;
  localparam logic [3:0] REG_USERC   = 4'h3;
  localparam logic [3:0] REG_PROGLEN = 4'h4;
  localparam logic [3:0] REG_CRC     = 4'h5;
  localparam logic [3:0] REG_PROGREQ = 4'h6;
  // status bit positions
  localparam int ST_BUSY = 0;
  localparam int ST_DONE = 1;
  localparam int ST_ERR  = 2;
  localparam int ST_SRC  = 3;
  // byte stream element from the image source
  typedef struct packed {
    logic       valid;
    logic [7:0] data;
  } sbl_byte_t;
  // ram write port
  typedef struct packed {
    logic        we;
    logic [15:0] addr;
    logic [31:0] data;
  } sbl_ram_wr_t;
  // security controls derived from the word
  typedef struct packed {
    logic       tap_off;
    logic       link_off;
    logic       redundant_on;
    logic [3:0] sector_lock;
    logic       tap_otp_off;
  } sbl_sec_ctl_t;
endpackage

/* File: test/sbl_mem_model.sv */
// partner model: otp array and embedded boot flash byte stream
`timescale 1ns/1ps
module sbl_mem_model (
  input  wire logic                           clk,
  input  wire logic                           rst_b,
  input  wire logic                           otp_rd_reg,
  input  wire logic [sbl_pkg::OTP_ADDR_W-1:0] otp_addr_reg,
  output logic [31:0]                         otp_rdata,
  input  wire logic                           flash_req_reg,
  output sbl_pkg::sbl_byte_t                  flash_byte
);
  logic [31:0] otp_mem [sbl_pkg::NUM_SECTORS*sbl_pkg::SECTOR_ROWS]; // four sectors
  logic [7:0]  flash_q [$]; // image bytes in wire order
  logic [1:0]  pace;        // stall pattern
  initial
  begin
    otp_rdata = 32'h5A5A5A5A;
    flash_byte = '0;
    pace = 2'h0;
  end
  ////////////////////////////////////////////////////////////////
  // otp row answers one cycle after request, else data scrambles
  always @(posedge clk)
  begin
    if (otp_rd_reg)
      otp_rdata <= otp_mem[otp_addr_reg];
    else
      otp_rdata <= ~otp_rdata;
  end
  ////////////////////////////////////////////////////////////////
  // flash bytes lsb first, one idle cycle in four
  always @(posedge clk)
  begin
    pace <= pace + 2'h1;
    if (rst_b && flash_req_reg && pace != 2'h3 && flash_q.size() > 0)
      flash_byte <= {1'b1, flash_q.pop_front()};
    else
      flash_byte <= {1'b0, ~flash_byte.data};
  end
endmodule

/* File: test/tb_secure_boot_image_loader.sv */
// testbench: boots images from flash and otp, checks security outputs
`timescale 1ns/1ps
`define CHK(g, e) begin compares++; if ((g) !== (e)) begin errors++; $display("[ERR] t=%0t got %h exp %h", $time, (g), (e)); end end
module tb_secure_boot_image_loader;
  localparam int RST_CYC = 4; // shortened reset process
  logic                           clk, rst_b, otp_rd_reg, flash_req_reg;
  logic [sbl_pkg::OTP_ADDR_W-1:0] otp_addr_reg, first_rd_addr;
  logic [31:0]                    otp_rdata, usercode_reg, reg_wdata, reg_rdata_reg, d, exp_crc;
  sbl_pkg::sbl_byte_t             flash_byte;
  sbl_pkg::sbl_ram_wr_t           ram_wr_reg;
  sbl_pkg::sbl_sec_ctl_t          sec_ctl_reg;
  logic                           cpu_start_reg, boot_err_reg, prog_req, prog_grant_reg;
  logic                           reg_wr, reg_rd, first_seen;
  logic [15:0]                    cpu_pc_reg, gpio_pd_reg, prog_addr;
  logic [23:0]                    prog_res_id;
  logic [3:0]                     reg_addr;
  logic [7:0]                     img [$];
  logic [31:0]                    exp_w [$], ram_d [$];
  logic [15:0]                    ram_a [$];
  int                             errors, compares, rel_cyc, first_rd_cyc;
  sbl_loader #(.GPIO_W(16), .RST_CYC(RST_CYC)) u_dut (.clk(clk), .rst_b(rst_b),
    .otp_rd_reg(otp_rd_reg), .otp_addr_reg(otp_addr_reg), .otp_rdata(otp_rdata),
    .flash_req_reg(flash_req_reg), .flash_byte(flash_byte), .ram_wr_reg(ram_wr_reg),
    .cpu_start_reg(cpu_start_reg), .cpu_pc_reg(cpu_pc_reg), .boot_err_reg(boot_err_reg),
    .gpio_pd_reg(gpio_pd_reg), .sec_ctl_reg(sec_ctl_reg), .usercode_reg(usercode_reg),
    .prog_res_id(prog_res_id), .prog_addr(prog_addr), .prog_req(prog_req),
    .prog_grant_reg(prog_grant_reg), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata_reg(reg_rdata_reg));
  sbl_mem_model u_mem (.clk(clk), .rst_b(rst_b), .otp_rd_reg(otp_rd_reg),
    .otp_addr_reg(otp_addr_reg), .otp_rdata(otp_rdata), .flash_req_reg(flash_req_reg),
    .flash_byte(flash_byte));
  initial
  begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end
  ////////////////////////////////////////////////////////////////
  // ram writes and first otp access after reset release
  always @(posedge clk)
  begin
    if (ram_wr_reg.we)
    begin
      ram_a.push_back(ram_wr_reg.addr);
      ram_d.push_back(ram_wr_reg.data);
    end
    if (!rst_b)
    begin
      rel_cyc <= 0;
      first_seen <= 1'b0;
    end
    else
    begin
      rel_cyc <= rel_cyc + 1;
      if (otp_rd_reg && !first_seen)
      begin
        first_seen <= 1'b1;
        first_rd_addr <= otp_addr_reg;
        first_rd_cyc <= rel_cyc;
      end
    end
  end
  ////////////////////////////////////////////////////////////////
  // helpers: crc byte step, image assembly, bus cycles
  function automatic logic [31:0] crc8(input logic [31:0] c, input logic [7:0] b);
    c = c ^ {24'h0, b};
    for (int k = 0; k < 8; k++)
      c = c[0] ? ((c >> 1) ^ sbl_pkg::CRC_POLY) : (c >> 1);
    return c;
  endfunction
  task automatic put32(input logic [31:0] w);
    for (int k = 0; k < 4; k++)
      img.push_back(w[8*k +: 8]);
  endtask
  task automatic rd(input logic [3:0] a);
    @(posedge clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clk);
    reg_rd <= 1'b0;
    #1 d = reg_rdata_reg;
  endtask
  task automatic wr(input logic [3:0] a, input logic [31:0] v);
    @(posedge clk);
    reg_addr <= a;
    reg_wdata <= v;
    reg_wr <= 1'b1;
    @(posedge clk);
    reg_wr <= 1'b0;
  endtask
  task automatic prog(input logic [23:0] id, input logic [1:0] sct, input logic e);
    @(posedge clk);
    prog_res_id <= id;
    prog_addr <= {5'h0, sct, 9'h0};
    prog_req <= 1'b1;
    repeat (2) @(posedge clk);
    #1 `CHK(prog_grant_reg, e)
    @(posedge clk);
    prog_req <= 1'b0;
  endtask
  // kind 0 good crc, 1 skip value, 2 residue left uninverted
  task automatic boot(input logic [31:0] sec, input int s, input int kind, input logic ok);
    logic [31:0] crc;
    int          n;
    rst_b <= 1'b0;
    repeat (6) @(posedge clk);
    `CHK(gpio_pd_reg, 16'hFFFF)
    img = {};
    exp_w = {};
    ram_a = {};
    ram_d = {};
    put32(s);
    for (int i = 0; i < s; i++)
    begin
      exp_w.push_back(32'h3C00_0000 + i * 32'h0107_0F13);
      put32(exp_w[i]);
    end
    crc = sbl_pkg::CRC_INIT;
    foreach (img[i]) crc = crc8(crc, img[i]);
    exp_crc = ~crc;
    put32(kind == 1 ? sbl_pkg::NO_CRC_MAGIC : (kind == 2 ? crc : ~crc));
    u_mem.otp_mem[sbl_pkg::OTP_SEC_ROW] = sec;
    u_mem.flash_q = {};
    if (sec[5])
      for (int i = 0; i < img.size() / 4; i++)
        u_mem.otp_mem[i] = {img[4*i+3], img[4*i+2], img[4*i+1], img[4*i]};
    else
      u_mem.flash_q = img;
    rst_b <= 1'b1;
    n = 0;
    while (cpu_start_reg !== 1'b1 && boot_err_reg !== 1'b1 && n < 3000)
    begin
      @(posedge clk);
      n++;
    end
    #1 `CHK(first_rd_addr, sbl_pkg::OTP_SEC_ROW)
    `CHK(first_rd_cyc >= RST_CYC, 1'b1)
    `CHK(cpu_start_reg, ok)
    `CHK(boot_err_reg, !ok)
    if (ok)
    begin
      `CHK(cpu_pc_reg, 16'h0000)
      `CHK(ram_a.size(), s)
      foreach (exp_w[i]) `CHK({ram_a[i], ram_d[i]}, {16'(4 * i), exp_w[i]})
    end
    `CHK(sec_ctl_reg, sbl_pkg::sbl_sec_ctl_t'({sec[0], sec[1], sec[7], sec[11:8], sec[13]}))
    `CHK(usercode_reg, {sec[31:22], 22'h0})
    `CHK(gpio_pd_reg, 16'h0000)
    rd(sbl_pkg::REG_STATUS);
    `CHK(d[3:0], {sec[5], !ok, ok, 1'b0})
  endtask
  task automatic summarize;
    $display("compares=%0d errors=%0d", compares, errors);
    if (errors == 0 && compares > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask
  initial
  begin
    repeat (60000) @(posedge clk);
    errors++;
    summarize();
  end
  ////////////////////////////////////////////////////////////////
  // main sequence
  initial
  begin
    {rst_b, reg_wr, reg_rd, prog_req, reg_addr, reg_wdata, prog_addr, prog_res_id} = '0;
    errors = 0;
    compares = 0;
    boot(32'hA5C2_8583, 5, 0, 1'b1);
    rd(sbl_pkg::REG_SEC);
    `CHK(d, 32'hA5C2_8583)
    rd(sbl_pkg::REG_PROGLEN);
    `CHK(d, 32'd5)
    rd(sbl_pkg::REG_CRC);
    `CHK(d, exp_crc)
    rd(sbl_pkg::REG_USERC);
    `CHK(d, 32'hA5C0_0000)
    rd(sbl_pkg::REG_GP);
    `CHK(d[6:0], 7'h05)
    wr(sbl_pkg::REG_GP, 32'hFFFF_FF55);
    rd(sbl_pkg::REG_GP);
    `CHK(d[6:0], 7'h55)
    wr(sbl_pkg::REG_SEC, 32'h0);
    rd(sbl_pkg::REG_SEC);
    `CHK(d, 32'hA5C2_8583)
    rd(4'hF);
    `CHK(d, 32'h0)
    for (int i = 0; i < 4; i++) prog(sbl_pkg::RES_OTP_ADDR, 2'(i), i[0]);
    prog(sbl_pkg::RES_OTP_DATA, 2'h1, 1'b1);
    prog(sbl_pkg::RES_OTP_CTRL, 2'h3, 1'b1);
    prog(24'h100201, 2'h1, 1'b0);
    $display("test flash_crc done");
    boot(32'h0, 0, 1, 1'b1);
    $display("test flash_skip done");
    boot(32'h0, 3, 2, 1'b0);
    $display("test flash_bad done");
    boot(32'h0000_30A0, 4, 0, 1'b1);
    for (int i = 0; i < 4; i++) prog(sbl_pkg::RES_OTP_ADDR, 2'(i), 1'b0);
    $display("test otp_boot done");
    summarize();
  end
endmodule
